// *** hw/dual_address_i2c_port_expander.sv ***
// Dual-address two-wire bus port expander with transition alert
// Overview of operation
// - Answers two addresses picked by select inputs
// - Address 101xxxx drives push-pull ports 8-15
// - Address 110xxxx: ports 0,1,6,7 and open-drain 2-5
// - Bus clock at most 400 kHz
// - Bus-clear input aborts transfer, frees bus
// - Open-drain bit high releases the pin
// - Reads return pin levels, not latches
// - Per-port flag latches any input change
// - Any transition sets latched alert, no mask
// - Twelve push-pull outputs, defaults from selects
// - Next addressed transaction clears all flags
// - Next access releases the alert
// - Bus-clear leaves alert untouched
// - Selects pick pullups and defaults per pair
`timescale 1ns/10ps
`default_nettype none

`include "port_expander_map.svh"

module dual_address_i2c_port_expander
  import port_expander_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,       // Power-on reset
  input  wire logic       busClear_n,  // Serial interface clear
  input  wire logic       scl,         // Bus clock level
  input  wire logic       sdaIn,       // Bus data level
  output pin_drive_t      sdaPin,      // Bus data drive
  input  wire addr_sel_t  addrSelLo,   // Low address select
  input  wire addr_sel_t  addrSelHi,   // High address select
  input  wire logic [3:0] openDrainIn, // Open-drain port levels
  output pin_drive_t [3:0] openDrainIo, // Open-drain port drive
  output logic [3:0]      pullupEn,    // Pullup enables, ports 2..5
  output logic [11:0]     pushPullOut, // Ports 0,1,6..15 in order
  output pin_drive_t      alertPin,    // Active-low alert drive
  output logic [3:0]      transFlags   // Latched change flags
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_t  state_reg;       // Serial interface state
  logic        sclPrev_reg;     // Bus clock, previous cycle
  logic        sdaPrev_reg;     // Bus data, previous cycle
  logic [7:0]  shift_reg;       // Address, write and read shifter
  logic [3:0]  bitCnt_reg;      // Bits moved in current byte
  logic        readMode_reg;    // Transfer is a read
  logic        highGrp_reg;     // Addressed group is ports 8..15
  logic        driveLow_reg;    // Pull bus data low
  logic        masterAck_reg;   // Master acknowledged read byte
  logic [15:0] portLatch_reg;   // Output latch, bit n is port n
  logic        defaultsDue_reg; // Power-up defaults not yet loaded
  logic        alert_reg;       // Alert latched

  logic        sclRise;         // Bus clock rising
  logic        sclFall;         // Bus clock falling
  logic        startCond;       // Data falls while clock high
  logic        stopCond;        // Data rises while clock high
  logic        busActive;       // Bus edges may be acted on
  logic [6:0]  addrLowGrp;      // Current address, ports 0..7
  logic [6:0]  addrHighGrp;     // Current address, ports 8..15
  logic        matchLow;        // Address byte hits low group
  logic        matchHigh;       // Address byte hits high group
  logic        accessHit;       // This device was addressed
  logic        writeStrobe;     // Data byte complete
  logic [7:0]  readByte;        // Pin levels of addressed group
  logic [15:0] portDefaults;    // Power-up defaults from selects
  logic        anyChange;       // Input edge seen this cycle

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  // Pins are synchronous; at 100 MHz a 400 kHz bit spans at least
  // MIN_CYCLES_PER_BIT cycles, so single-cycle edge detection is safe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sdaIn;
    end
  end

  assign sclRise   = scl & ~sclPrev_reg;
  assign sclFall   = ~scl & sclPrev_reg;
  assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
  assign stopCond  = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;
  assign busActive = busClear_n & ~startCond & ~stopCond;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Low bits are the two select codes; the high select is recoded
  // so that the pairs span all 32 addresses
  assign addrLowGrp  = {`ADDR_PREFIX_LOW_GRP,
                        addrSelHi ^ `HI_SEL_CODE_XOR, addrSelLo};
  assign addrHighGrp = {`ADDR_PREFIX_HIGH_GRP,
                        addrSelHi ^ `HI_SEL_CODE_XOR, addrSelLo};
  assign matchLow    = (shift_reg[7:1] == addrLowGrp);
  assign matchHigh   = (shift_reg[7:1] == addrHighGrp);

  // Pulses once per transaction that targets either address
  assign accessHit   = busActive & sclFall & (state_reg == ST_ADDR) &
                       (bitCnt_reg == `BYTE_BIT_COUNT) &
                       (matchLow | matchHigh);

  assign writeStrobe = busActive & sclFall &
                       (state_reg == ST_WR_DATA) &
                       (bitCnt_reg == `BYTE_BIT_COUNT);

  // Live pin levels; open-drain bits show the wire, not the latch
  assign readByte = highGrp_reg ? portLatch_reg[15:8]
                  : {portLatch_reg[7:6], openDrainIn,
                     portLatch_reg[1:0]};

  // ----------------------------------------------------------------
  // Serial interface state machine
  // ----------------------------------------------------------------
  // Start and stop override any state; bus-clear overrides both
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 8'h00;
      bitCnt_reg    <= 4'h0;
      readMode_reg  <= 1'b0;
      highGrp_reg   <= 1'b0;
      driveLow_reg  <= 1'b0;
      masterAck_reg <= 1'b0;
    end
    else if (!busClear_n)
    begin
      // Drop the transfer and release data; alert logic is elsewhere
      state_reg    <= ST_IDLE;
      bitCnt_reg   <= 4'h0;
      driveLow_reg <= 1'b0;
    end
    else if (startCond)
    begin
      // Also covers repeated start in mid-transfer
      state_reg    <= ST_ADDR;
      bitCnt_reg   <= 4'h0;
      driveLow_reg <= 1'b0;
    end
    else if (stopCond)
    begin
      state_reg    <= ST_IDLE;
      driveLow_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR:
        begin
          if (sclRise)
          begin
            shift_reg  <= {shift_reg[6:0], sdaIn};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          else if (sclFall && bitCnt_reg == `BYTE_BIT_COUNT)
          begin
            if (matchLow || matchHigh)
            begin
              state_reg    <= ST_ADDR_ACK;
              driveLow_reg <= 1'b1;
              readMode_reg <= shift_reg[`RW_BIT_POS];
              highGrp_reg  <= matchHigh;
            end
            else
              state_reg <= ST_IDLE;  // Not ours: wait for next start
          end
        end
        ST_ADDR_ACK:
        begin
          if (sclFall)
          begin
            bitCnt_reg <= 4'h0;
            if (readMode_reg)
            begin
              // Sample the pins at the start of the byte
              shift_reg    <= readByte;
              driveLow_reg <= ~readByte[7];
              state_reg    <= ST_RD_DATA;
            end
            else
            begin
              driveLow_reg <= 1'b0;
              state_reg    <= ST_WR_DATA;
            end
          end
        end
        ST_WR_DATA:
        begin
          if (sclRise)
          begin
            shift_reg  <= {shift_reg[6:0], sdaIn};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          else if (writeStrobe)
          begin
            state_reg    <= ST_WR_ACK;
            driveLow_reg <= 1'b1;
          end
        end
        ST_WR_ACK:
        begin
          if (sclFall)
          begin
            // Further bytes rewrite the same group
            driveLow_reg <= 1'b0;
            bitCnt_reg   <= 4'h0;
            state_reg    <= ST_WR_DATA;
          end
        end
        ST_RD_DATA:
        begin
          if (sclRise)
            bitCnt_reg <= bitCnt_reg + 4'h1;
          else if (sclFall && bitCnt_reg == `BYTE_BIT_COUNT)
          begin
            driveLow_reg <= 1'b0;  // Release for the master's ack
            state_reg    <= ST_RD_ACK;
          end
          else if (sclFall)
          begin
            shift_reg    <= {shift_reg[6:0], 1'b0};
            driveLow_reg <= ~shift_reg[6];
          end
        end
        ST_RD_ACK:
        begin
          if (sclRise)
            masterAck_reg <= ~sdaIn;
          else if (sclFall)
          begin
            bitCnt_reg <= 4'h0;
            if (masterAck_reg)
            begin
              shift_reg    <= readByte;
              driveLow_reg <= ~readByte[7];
              state_reg    <= ST_RD_DATA;
            end
            else
              state_reg <= ST_IDLE;  // Not acknowledged: stop sending
          end
        end
        default:
        begin
          // Idle and any stray code wait for a start
          state_reg    <= ST_IDLE;
          driveLow_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output latch and power-up defaults
  // ----------------------------------------------------------------
  // Selects on a bus line read high at power-up; any connection but
  // ground gives a high default. Nibbles: 15..12, 11..8, 7..4, 3..0
  assign portDefaults = {{4{addrSelHi != SEL_GND}},
                         {4{addrSelLo != SEL_GND}},
                         {4{addrSelHi != SEL_GND}},
                         {4{addrSelLo != SEL_GND}}};

  // Straps are caught on the first edge after reset release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portLatch_reg   <= 16'h0000;
      defaultsDue_reg <= 1'b1;
    end
    else if (defaultsDue_reg)
    begin
      portLatch_reg   <= portDefaults;
      defaultsDue_reg <= 1'b0;
    end
    else if (writeStrobe && highGrp_reg)
      portLatch_reg[15:8] <= shift_reg;
    else if (writeStrobe)
      portLatch_reg[7:0]  <= shift_reg;
  end

  // ----------------------------------------------------------------
  // Transition flags and alert
  // ----------------------------------------------------------------
  transition_detect #(.WIDTH (`OD_PORT_COUNT)) u_transition_detect (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .pinIn      (openDrainIn),
    .clearFlags (accessHit),
    .flags      (transFlags),
    .anyChange  (anyChange)
  );

  // No mask; a change in the clearing cycle keeps the alert set.
  // Only power-on reset and an access clear it, never bus-clear.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      alert_reg <= 1'b0;
    else if (anyChange)
      alert_reg <= 1'b1;
    else if (accessHit)
      alert_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign sdaPin   = '{level: 1'b0, oe: driveLow_reg};
  assign alertPin = '{level: 1'b0, oe: alert_reg};

  // A high latch bit releases the port so it can serve as input
  for (genvar i = 0; i < `OD_PORT_COUNT; i++)
  begin : g_od
    assign openDrainIo[i].level = 1'b0;
    assign openDrainIo[i].oe = ~portLatch_reg[`OD_PORT_LSB + i];
  end

  assign pullupEn[1:0] = {2{addrSelLo != SEL_GND}};
  assign pullupEn[3:2] = {2{addrSelHi != SEL_GND}};

  assign pushPullOut = {portLatch_reg[15:6], portLatch_reg[1:0]};

endmodule : dual_address_i2c_port_expander

`default_nettype wire

// *** hw/port_expander_map.svh ***
// Constant map of the dual-address serial port expander
`ifndef PORT_EXPANDER_MAP_SVH
`define PORT_EXPANDER_MAP_SVH

// ----------------------------------------------------------------
// Slave address layout
// ----------------------------------------------------------------
`define ADDR_PREFIX_HIGH_GRP 3'h5   // Upper address bits, ports 8..15
`define ADDR_PREFIX_LOW_GRP  3'h6   // Upper address bits, ports 0..7
`define ADDR_SPACE_SIZE      32     // Addresses the two selects span
`define HI_SEL_CODE_XOR      2'h2   // Recodes the high select field

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define BYTE_BIT_COUNT       4'h8   // Bits per byte on the bus
`define RW_BIT_POS           0      // Read/write flag in address byte

// ----------------------------------------------------------------
// Port layout in the 16-bit output latch
// ----------------------------------------------------------------
`define OD_PORT_LSB          2      // First open-drain port
`define OD_PORT_MSB          5      // Last open-drain port
`define OD_PORT_COUNT        4      // Open-drain port count

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BUS_MAX_RATE_KHZ     400    // Fastest legal bus clock
`define MCLK_RATE_KHZ        100000 // Core clock rate
`define MIN_CYCLES_PER_BIT   (`MCLK_RATE_KHZ / `BUS_MAX_RATE_KHZ)

`endif

// *** hw/port_expander_pkg.sv ***
// Types shared by the port expander design files
package port_expander_pkg;

  // ----------------------------------------------------------------
  // Four-level address select connection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_GND   = 2'h0,
    SEL_VPLUS = 2'h1,
    SEL_SCL   = 2'h2,
    SEL_SDA   = 2'h3
  } addr_sel_t;

  // ----------------------------------------------------------------
  // Serial interface states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_ADDR    = 3'h1,
    ST_ADDR_ACK = 3'h2,
    ST_WR_DATA = 3'h3,
    ST_WR_ACK  = 3'h4,
    ST_RD_DATA = 3'h5,
    ST_RD_ACK  = 3'h6
  } bus_state_t;

  // ----------------------------------------------------------------
  // Open-drain pin drive: level and enable travel together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic level;  // Level driven while enabled, always low here
    logic oe;     // High while the pin is pulled low
  } pin_drive_t;

endpackage : port_expander_pkg

// *** hw/transition_detect.sv ***
// Per-port latched transition flags for the open-drain inputs
`timescale 1ns/10ps
`default_nettype none

`include "port_expander_map.svh"

module transition_detect
  import port_expander_pkg::*;
#(
  parameter int WIDTH = `OD_PORT_COUNT
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,      // Sampled port levels
  input  wire logic             clearFlags, // Access pulse
  output logic      [WIDTH-1:0] flags,      // Latched change flags
  output logic                  anyChange   // Edge seen this cycle
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] prev_reg;   // Last cycle's pin levels
  logic [1:0]       primed_reg; // Edges since reset, as a shift
  logic [WIDTH-1:0] edgeSeen;   // Per-bit change this cycle

  // Two priming edges: reset value and default load would fake edges
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_reg   <= '0;
      primed_reg <= 2'h0;
    end
    else
    begin
      prev_reg   <= pinIn;
      primed_reg <= {primed_reg[0], 1'b1};
    end
  end

  // One flag per port; an edge in the clearing cycle survives
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_flag
    assign edgeSeen[i] = primed_reg[1] & (pinIn[i] ^ prev_reg[i]);

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        flags[i] <= 1'b0;
      else if (edgeSeen[i])
        flags[i] <= 1'b1;
      else if (clearFlags)
        flags[i] <= 1'b0;
    end
  end

  assign anyChange = |edgeSeen;

endmodule : transition_detect

`default_nettype wire

// *** tb/bus_master_model.sv ***
// Two-wire bus master model driving the expander's bus pins
`timescale 1ns/10ps
`default_nettype none

module bus_master_model
  import port_expander_pkg::*;
#(
  parameter int QUARTER = 64  // Clock cycles per quarter bit
)
(
  input  wire logic       mclk,
  input  wire pin_drive_t slaveDrive, // Slave data pull-down
  output logic            scl,        // Bus clock
  output logic            sdaWire     // Resolved data wire
);
  logic sdaDrv;  // Master data drive, 1 releases the line

  // Pull-up on the wire: low if either side pulls it down
  assign sdaWire = sdaDrv & ~slaveDrive.oe;

  // Bus idles with both lines released
  initial
  begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  // Four quarters per bit keep the clock at or below 400 kHz
  task automatic pause();
    repeat (QUARTER) @(posedge mclk);
  endtask : pause

  // Start or repeated start: data falls while clock high
  task automatic busStart();
    sdaDrv <= 1'b1;
    pause();
    scl <= 1'b1;
    pause();
    sdaDrv <= 1'b0;
    pause();
    scl <= 1'b0;
    pause();
  endtask : busStart

  // Stop: data rises while clock high
  task automatic busStop();
    sdaDrv <= 1'b0;
    pause();
    scl <= 1'b1;
    pause();
    sdaDrv <= 1'b1;
    pause();
  endtask : busStop

  // One bit; data only changes while the clock is low
  task automatic busBit(input logic b, output logic r);
    sdaDrv <= b;
    pause();
    scl <= 1'b1;
    pause();
    r = sdaWire;
    pause();
    scl <= 1'b0;
    pause();
  endtask : busBit

  // Byte out MSB first, then the slave's acknowledge
  task automatic busWrite(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      busBit(d[i], r);
    busBit(1'b1, r);
    ack = ~r;
  endtask : busWrite

  // Byte in MSB first; master acknowledges when more follow
  task automatic busRead(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      busBit(1'b1, r);
      d[i] = r;
    end
    busBit(~more, r);
  endtask : busRead
endmodule : bus_master_model

`default_nettype wire

// *** tb/dual_address_i2c_port_expander_test.sv ***
// Self-checking bench for the dual-address port expander
`timescale 1ns/10ps
`default_nettype none

`define CHECK(got, exp) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module dual_address_i2c_port_expander_test
  import port_expander_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             mclk, rst_n, busClear_n; // Clock and resets
  addr_sel_t        addrSelLo, addrSelHi;    // Address selects
  logic             scl, sdaIn;              // Bus wires
  pin_drive_t       sdaPin, alertPin;        // Slave pin drives
  logic [3:0]       extDrv;      // External source on ports 2..5
  logic [3:0]       openDrainIn; // Resolved port wires
  logic [3:0]       odOe;        // Port pull-downs, bit0 = port 2
  pin_drive_t [3:0] openDrainIo;
  logic [3:0]       pullupEn, transFlags;
  logic [11:0]      pushPullOut;
  logic             ack;         // Acknowledge seen by the master
  logic [7:0]       rd;          // Byte read back
  int               mismatches, nTests, cycles;

  // Port wire is low if the device or the external source pulls
  assign odOe = {openDrainIo[3].oe, openDrainIo[2].oe,
                 openDrainIo[1].oe, openDrainIo[0].oe};
  assign openDrainIn = extDrv & ~odOe;

  dual_address_i2c_port_expander dut_u (
    .mclk(mclk), .rst_n(rst_n), .busClear_n(busClear_n),
    .scl(scl), .sdaIn(sdaIn), .sdaPin(sdaPin),
    .addrSelLo(addrSelLo), .addrSelHi(addrSelHi),
    .openDrainIn(openDrainIn), .openDrainIo(openDrainIo),
    .pullupEn(pullupEn), .pushPullOut(pushPullOut),
    .alertPin(alertPin), .transFlags(transFlags));

  bus_master_model #(.QUARTER(64)) master_u (
    .mclk(mclk), .slaveDrive(sdaPin), .scl(scl), .sdaWire(sdaIn));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // About 41k cycles expected; the ceiling leaves a margin
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      summarize();
    end
  end

  // Pulse the serial interface clear for one edge
  task automatic pulseClear();
    @(posedge mclk) busClear_n <= 1'b0;
    @(posedge mclk) busClear_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : pulseClear

  // Whole one-byte write; data only goes out when acknowledged
  task automatic writeGroup(input logic [6:0] a, input logic [7:0] d);
    logic ackD;
    master_u.busStart();
    master_u.busWrite({a, 1'b0}, ack);
    if (ack)
      master_u.busWrite(d, ackD);
    master_u.busStop();
  endtask : writeGroup

  // ----------------------------------------------------------------
  // Scenarios; selects give low bits 0000
  // ----------------------------------------------------------------
  task automatic testDefaults();
    `CHECK(pushPullOut, 12'hF0C)
    `CHECK(pullupEn, 4'hC)
    `CHECK(odOe, 4'h3)
    `CHECK({alertPin.oe, transFlags}, 5'h00)
    $display("testDefaults done");
  endtask : testDefaults

  task automatic testWrites();
    writeGroup(7'h50, 8'hA5);
    `CHECK(ack, 1'b1)
    `CHECK(pushPullOut, 12'hA5C)
    writeGroup(7'h60, 8'hBD);
    `CHECK(ack, 1'b1)
    `CHECK(pushPullOut, 12'hA59)
    `CHECK(odOe, 4'h0)
    `CHECK(openDrainIn, 4'hF)
    writeGroup(7'h70, 8'h00);
    `CHECK(ack, 1'b0)
    writeGroup(7'h61, 8'h00);
    `CHECK(ack, 1'b0)
    `CHECK(pushPullOut, 12'hA59)
    $display("testWrites done");
  endtask : testWrites

  // Released ports rose, so flags are pending on entry
  task automatic testTransitions();
    `CHECK(transFlags, 4'h3)
    master_u.busStart();
    master_u.busWrite(8'hA1, ack);
    `CHECK(transFlags, 4'h0)
    `CHECK(alertPin.oe, 1'b0)
    master_u.busRead(1'b0, rd);
    `CHECK(rd, 8'hA5)
    master_u.busStop();
    // A glitch that reverts must still be caught
    @(posedge mclk) extDrv <= 4'hD;
    repeat (3) @(posedge mclk) extDrv <= 4'hF;
    repeat (3) @(posedge mclk);
    `CHECK(transFlags, 4'h2)
    `CHECK(alertPin.oe, 1'b1)
    pulseClear();
    `CHECK(alertPin.oe, 1'b1)
    `CHECK(transFlags, 4'h2)
    @(posedge mclk) extDrv <= 4'h5;
    repeat (3) @(posedge mclk);
    `CHECK(transFlags, 4'hA)
    master_u.busStart();
    master_u.busWrite(8'hC1, ack);
    `CHECK(ack, 1'b1)
    `CHECK(transFlags, 4'h0)
    `CHECK(alertPin.oe, 1'b0)
    master_u.busRead(1'b1, rd);
    `CHECK(rd, 8'h95)
    master_u.busRead(1'b0, rd);
    `CHECK(rd, 8'h95)
    master_u.busStop();
    $display("testTransitions done");
  endtask : testTransitions

  // Clear while the slave holds the data line in its acknowledge
  task automatic testAbort();
    logic [7:0] a;
    logic       r;
    a = 8'hA0;
    master_u.busStart();
    for (int i = 7; i >= 0; i--)
      master_u.busBit(a[i], r);
    `CHECK(sdaPin.oe, 1'b1)
    pulseClear();
    `CHECK(sdaPin.oe, 1'b0)
    master_u.busStop();
    writeGroup(7'h50, 8'h3C);
    `CHECK(ack, 1'b1)
    `CHECK(pushPullOut, 12'h3C9)
    // Live selects move both addresses and the pullups
    addrSelLo <= SEL_SDA;
    addrSelHi <= SEL_GND;
    writeGroup(7'h5B, 8'h81);
    `CHECK({ack, pullupEn}, 5'h13)
    `CHECK(pushPullOut, 12'h819)
    $display("testAbort done");
  endtask : testAbort

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n      = 1'b0;
    busClear_n = 1'b1;
    addrSelLo  = SEL_GND;
    addrSelHi  = SEL_SCL;
    extDrv     = 4'hF;
    mismatches = 0;
    nTests     = 0;
    cycles     = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    testDefaults();
    testWrites();
    testTransitions();
    testAbort();
    summarize();
  end
endmodule : dual_address_i2c_port_expander_test

bind dual_address_i2c_port_expander port_expander_props props_u (
  .mclk(mclk), .rst_n(rst_n), .busClear_n(busClear_n),
  .scl(scl), .sdaIn(sdaIn), .sdaPin(sdaPin),
  .addrSelLo(addrSelLo), .addrSelHi(addrSelHi),
  .openDrainIn(openDrainIn), .openDrainIo(openDrainIo),
  .pullupEn(pullupEn), .pushPullOut(pushPullOut),
  .alertPin(alertPin), .transFlags(transFlags));

`default_nettype wire

// *** tb/port_expander_props.sv ***
// Concurrent checks on the port expander top-level ports
`timescale 1ns/10ps
`default_nettype none

module port_expander_props
  import port_expander_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             busClear_n,
  input wire logic             scl,
  input wire logic             sdaIn,
  input wire pin_drive_t       sdaPin,
  input wire addr_sel_t        addrSelLo,
  input wire addr_sel_t        addrSelHi,
  input wire logic [3:0]       openDrainIn,
  input wire pin_drive_t [3:0] openDrainIo,
  input wire logic [3:0]       pullupEn,
  input wire logic [11:0]      pushPullOut,
  input wire pin_drive_t       alertPin,
  input wire logic [3:0]       transFlags
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [1:0] upCnt_reg;  // Edges since reset, saturating
  logic [3:0] prevIn_reg; // Port levels one edge back
  logic       primed;     // Default loading is over
  logic [3:0] chgNow;     // Ports that moved this cycle

  // Defaults load on the first edge, so early checks would misfire
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      upCnt_reg <= 2'h0;
    else if (upCnt_reg != 2'h3)
      upCnt_reg <= upCnt_reg + 2'h1;

  // Port history for change detection
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      prevIn_reg <= 4'h0;
    else
      prevIn_reg <= openDrainIn;

  assign primed = (upCnt_reg >= 2'h2);
  assign chgNow = openDrainIn ^ prevIn_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_alert_set : assert property (
    primed && (chgNow != 4'h0) |=> alertPin.oe)
    else $error("alert not raised after a port change");
  a_flag_set : assert property (
    primed && (chgNow != 4'h0)
    |=> ((transFlags & $past(chgNow)) == $past(chgNow)))
    else $error("flag missing after a port change");
  a_clear_keeps : assert property (
    primed && !busClear_n && (chgNow == 4'h0)
    |=> (alertPin.oe == $past(alertPin.oe))
        && (transFlags == $past(transFlags)))
    else $error("bus clear disturbed alert or flags");
  a_clear_frees : assert property (
    !busClear_n |=> !sdaPin.oe)
    else $error("data line held after bus clear");
  a_pullup_sel : assert property (
    pullupEn == {{2{addrSelHi != SEL_GND}}, {2{addrSelLo != SEL_GND}}})
    else $error("pullup enables disagree with selects");
  a_out_on_ack : assert property (
    primed && (pushPullOut != $past(pushPullOut)) |-> sdaPin.oe)
    else $error("outputs changed outside a data acknowledge");
  a_ack_scl_low : assert property (
    $rose(sdaPin.oe) |-> !scl)
    else $error("data line pulled while bus clock high");
  a_alert_clear : assert property (
    $fell(alertPin.oe) |-> $rose(sdaPin.oe))
    else $error("alert released without an access");
  a_flags_clear : assert property (
    ($past(transFlags) != 4'h0) && (transFlags == 4'h0)
    |-> $rose(sdaPin.oe))
    else $error("flags cleared without an access");

  // Main scenarios reached
  c_alert_clr : cover property ($fell(alertPin.oe));
  c_bus_clear : cover property (!busClear_n ##1 busClear_n);
  c_out_write : cover property (primed && $changed(pushPullOut));
endmodule : port_expander_props

`default_nettype wire
